/* File: src/poll_sched_pkg.sv */
// Package of constants and types for the periodic poll scheduler
package poll_sched_pkg;

    // Timing
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned TICK_MS         = 10;
    localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned BACKOFF_MS      = 2000;
    localparam int unsigned BACKOFF_TICKS   = BACKOFF_MS / TICK_MS;

    // Limits
    localparam int unsigned SCAN_ENTRIES    = 48;
    localparam int unsigned MAX_COUNT       = 128;
    localparam int unsigned MBOX_TOP        = 2048;
    localparam int unsigned LOCAL_GAP_LO    = 32;
    localparam int unsigned LOCAL_GAP_HI    = 65;

    // Register offsets (byte addresses)
    localparam logic [11:0] ADDR_CTRL       = 12'h000;
    localparam logic [11:0] ADDR_INTERVAL   = 12'h004;
    localparam logic [11:0] ADDR_XFER_RD    = 12'h008;
    localparam logic [11:0] ADDR_XFER_RDA   = 12'h00c;
    localparam logic [11:0] ADDR_XFER_WR    = 12'h010;
    localparam logic [11:0] ADDR_XFER_WRA   = 12'h014;
    localparam logic [11:0] ADDR_XFER_ROUTE = 12'h018;
    localparam logic [11:0] ADDR_STATUS     = 12'h01c;
    localparam logic [11:0] ADDR_SCAN_STAT0 = 12'h020;
    localparam logic [11:0] ADDR_SCAN_STAT1 = 12'h024;
    localparam logic [11:0] ADDR_SCAN_STAT2 = 12'h028;
    localparam logic [11:0] ADDR_SCAN_BASE  = 12'h100;

    // Control fields
    localparam int unsigned CTRL_OPEN_PROTO = 0;
    localparam int unsigned CTRL_STAT_EN    = 1;

    // Reset values
    localparam logic [15:0] INTERVAL_RST    = 16'h0000;

    // Message kinds
    typedef enum logic [1:0] {
        MSG_XFER_RD = 2'b00,
        MSG_XFER_WR = 2'b01,
        MSG_SCAN_RD = 2'b10,
        MSG_SCAN_WR = 2'b11
    } msg_kind_t;

    // Scheduler states
    typedef enum logic [1:0] {
        ST_WAIT    = 2'b00,
        ST_PICK    = 2'b01,
        ST_BACKOFF = 2'b10
    } sched_state_t;

endpackage

/* File: src/poll_sched.sv */
// Periodic poll scheduler for one serial port
`timescale 1ns/100ps
module poll_sched
    import poll_sched_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Message request
    output logic             msg_req_o,
    output logic      [1:0]  msg_kind_o,
    output logic      [5:0]  msg_entry_o,
    output logic      [15:0] msg_remote_o,
    output logic      [11:0] msg_local_o,
    output logic      [7:0]  msg_count_o,
    output logic      [15:0] msg_route_o,
    input  wire logic        msg_ack_i,
    // Reply
    input  wire logic        rsp_valid_i,
    input  wire logic        rsp_ok_i,
    // Port role
    output logic             port_master_o,
    output logic             slave_refuse_o
);

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [1:0]   ctrl_q;
    logic [15:0]  interval_q;
    logic [7:0]   rd_cnt_q;
    logic [15:0]  rd_rem_q;
    logic [11:0]  rd_loc_q;
    logic [7:0]   wr_cnt_q;
    logic [15:0]  wr_rem_q;
    logic [11:0]  wr_loc_q;
    logic [15:0]  xroute_q;
    logic [11:0]  sc_loc_q [SCAN_ENTRIES];
    logic [15:0]  sc_rem_q [SCAN_ENTRIES];
    logic [7:0]   sc_cnt_q [SCAN_ENTRIES];
    logic         sc_dir_q [SCAN_ENTRIES];
    logic [15:0]  sc_rte_q [SCAN_ENTRIES];
    logic [SCAN_ENTRIES-1:0] stat_q;
    logic [SCAN_ENTRIES-1:0] valid;
    logic         busy_q;
    logic         next_wr_q;
    logic [5:0]   ptr_q;
    logic [23:0]  div_q;
    logic [15:0]  tick_cnt_q;
    sched_state_t state_q;
    logic         tick;
    logic         wb_hit;
    logic         any_valid;
    logic         xfer_rd_ok;
    logic         xfer_wr_ok;
    logic         scan_on;
    logic         xfer_on;
    logic [5:0]   last_entry_q;

    ////////////////////////////////////////////////////////////////////////
    // Validity decode
    function automatic logic local_ok(input logic [11:0] loc);
        return (loc >= 12'h001 && loc <= 12'(LOCAL_GAP_LO)) ||
               (loc >= 12'(LOCAL_GAP_HI) && loc <= 12'(MBOX_TOP));
    endfunction

    function automatic logic count_ok(input logic [7:0] cnt);
        return cnt != 8'h00 && cnt <= 8'(MAX_COUNT);
    endfunction

    genvar g;
    generate
        for (g = 0; g < SCAN_ENTRIES; g++) begin : g_valid
            assign valid[g] = local_ok(sc_loc_q[g]) &&
                              sc_rem_q[g] != 16'h0000 &&
                              count_ok(sc_cnt_q[g]) &&
                              sc_rte_q[g] != 16'h0000;
        end
    endgenerate

    assign any_valid  = |valid;
    assign scan_on    = any_valid && interval_q != 16'h0000;
    assign xfer_rd_ok = count_ok(rd_cnt_q) && rd_loc_q != 12'h000 &&
                        rd_loc_q <= 12'(MBOX_TOP);
    assign xfer_wr_ok = count_ok(wr_cnt_q) && wr_loc_q != 12'h000 &&
                        wr_loc_q <= 12'(MBOX_TOP);
    assign xfer_on    = !any_valid && interval_q != 16'h0000 &&
                        rd_cnt_q != 8'h00 &&
                        (xfer_rd_ok || xfer_wr_ok);

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= wb_hit;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q     <= 2'b00;
            interval_q <= INTERVAL_RST;
            rd_cnt_q   <= 8'h00;
            rd_rem_q   <= 16'h0000;
            rd_loc_q   <= 12'h000;
            wr_cnt_q   <= 8'h00;
            wr_rem_q   <= 16'h0000;
            wr_loc_q   <= 12'h000;
            xroute_q   <= 16'h0000;
            for (int i = 0; i < SCAN_ENTRIES; i++) begin
                sc_loc_q[i] <= 12'h000;
                sc_rem_q[i] <= 16'h0000;
                sc_cnt_q[i] <= 8'h00;
                sc_dir_q[i] <= 1'b0;
                sc_rte_q[i] <= 16'h0000;
            end
        end else if (ce_i && wb_hit && wb_we_i && wb_sel_i == 4'hf) begin
            case (wb_adr_i)
                ADDR_CTRL:       ctrl_q     <= wb_dat_i[1:0];
                ADDR_INTERVAL:   interval_q <= wb_dat_i[15:0];
                ADDR_XFER_RD:    rd_cnt_q   <= wb_dat_i[7:0];
                ADDR_XFER_RDA: begin
                    rd_rem_q <= wb_dat_i[15:0];
                    rd_loc_q <= wb_dat_i[27:16];
                end
                ADDR_XFER_WR:    wr_cnt_q   <= wb_dat_i[7:0];
                ADDR_XFER_WRA: begin
                    wr_rem_q <= wb_dat_i[15:0];
                    wr_loc_q <= wb_dat_i[27:16];
                end
                ADDR_XFER_ROUTE: xroute_q   <= wb_dat_i[15:0];
                default: begin
                    for (int i = 0; i < SCAN_ENTRIES; i++) begin
                        if (wb_adr_i == ADDR_SCAN_BASE + 12'(i * 8)) begin
                            sc_rem_q[i] <= wb_dat_i[15:0];
                            sc_loc_q[i] <= wb_dat_i[27:16];
                        end
                        if (wb_adr_i == ADDR_SCAN_BASE + 12'(i * 8 + 4)) begin
                            sc_cnt_q[i] <= wb_dat_i[7:0];
                            sc_dir_q[i] <= wb_dat_i[8];
                            sc_rte_q[i] <= wb_dat_i[31:16];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_dat_o <= 32'h0000_0000;
            if (wb_hit && !wb_we_i) begin
                case (wb_adr_i)
                    ADDR_CTRL:       wb_dat_o <= {30'h0, ctrl_q};
                    ADDR_INTERVAL:   wb_dat_o <= {16'h0, interval_q};
                    ADDR_XFER_RD:    wb_dat_o <= {24'h0, rd_cnt_q};
                    ADDR_XFER_RDA:   wb_dat_o <= {4'h0, rd_loc_q, rd_rem_q};
                    ADDR_XFER_WR:    wb_dat_o <= {24'h0, wr_cnt_q};
                    ADDR_XFER_WRA:   wb_dat_o <= {4'h0, wr_loc_q, wr_rem_q};
                    ADDR_XFER_ROUTE: wb_dat_o <= {16'h0, xroute_q};
                    ADDR_STATUS:     wb_dat_o <= {24'h0, ptr_q, busy_q, scan_on};
                    ADDR_SCAN_STAT0: wb_dat_o <= ctrl_q[CTRL_STAT_EN] ?
                                                 {16'h0, stat_q[15:0]} : 32'h0;
                    ADDR_SCAN_STAT1: wb_dat_o <= ctrl_q[CTRL_STAT_EN] ?
                                                 {16'h0, stat_q[31:16]} : 32'h0;
                    ADDR_SCAN_STAT2: wb_dat_o <= ctrl_q[CTRL_STAT_EN] ?
                                                 {16'h0, stat_q[47:32]} : 32'h0;
                    default: begin
                        for (int i = 0; i < SCAN_ENTRIES; i++) begin
                            if (wb_adr_i == ADDR_SCAN_BASE + 12'(i * 8))
                                wb_dat_o <= {4'h0, sc_loc_q[i], sc_rem_q[i]};
                            if (wb_adr_i == ADDR_SCAN_BASE + 12'(i * 8 + 4))
                                wb_dat_o <= {sc_rte_q[i], 7'h0, sc_dir_q[i], sc_cnt_q[i]};
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tick of 10 ms
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q <= 24'h000000;
        end else if (ce_i) begin
            div_q <= (div_q == 24'(TICK_DIV - 1)) ? 24'h000000 : div_q + 24'h000001;
        end
    end
    assign tick = ce_i && (div_q == 24'(TICK_DIV - 1));

    ////////////////////////////////////////////////////////////////////////
    // Scheduler
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q    <= ST_WAIT;
            tick_cnt_q <= 16'h0000;
            msg_req_o  <= 1'b0;
            msg_kind_o <= MSG_XFER_RD;
            msg_entry_o  <= 6'h00;
            msg_remote_o <= 16'h0000;
            msg_local_o  <= 12'h000;
            msg_count_o  <= 8'h00;
            msg_route_o  <= 16'h0000;
            busy_q     <= 1'b0;
            next_wr_q  <= 1'b0;
            ptr_q      <= 6'h00;
            last_entry_q <= 6'h00;
        end else if (ce_i) begin
            if (msg_req_o && msg_ack_i) begin
                msg_req_o <= 1'b0;
            end
            if (rsp_valid_i) begin
                busy_q <= 1'b0;
            end
            case (state_q)
                ST_WAIT: begin
                    if (!(scan_on || xfer_on)) begin
                        tick_cnt_q <= 16'h0000;
                    end else if (tick) begin
                        if (tick_cnt_q + 16'h0001 >= interval_q) begin
                            tick_cnt_q <= 16'h0000;
                            if (busy_q && !rsp_valid_i) begin
                                state_q <= ST_BACKOFF;
                            end else begin
                                state_q <= ST_PICK;
                            end
                        end else begin
                            tick_cnt_q <= tick_cnt_q + 16'h0001;
                        end
                    end
                end
                ST_BACKOFF: begin
                    if (tick) begin
                        if (tick_cnt_q + 16'h0001 >= 16'(BACKOFF_TICKS)) begin
                            tick_cnt_q <= 16'h0000;
                            state_q    <= ST_PICK;
                        end else begin
                            tick_cnt_q <= tick_cnt_q + 16'h0001;
                        end
                    end
                end
                ST_PICK: begin
                    if (msg_req_o) begin
                        state_q <= ST_PICK;
                    end else if (scan_on) begin
                        if (valid[ptr_q]) begin
                            msg_req_o    <= 1'b1;
                            busy_q       <= 1'b1;
                            msg_kind_o   <= sc_dir_q[ptr_q] ? MSG_SCAN_WR : MSG_SCAN_RD;
                            msg_entry_o  <= ptr_q;
                            msg_remote_o <= sc_rem_q[ptr_q];
                            msg_local_o  <= sc_loc_q[ptr_q];
                            msg_count_o  <= sc_cnt_q[ptr_q];
                            msg_route_o  <= sc_rte_q[ptr_q];
                            last_entry_q <= ptr_q;
                            state_q      <= ST_WAIT;
                        end
                        ptr_q <= (ptr_q == 6'(SCAN_ENTRIES - 1)) ? 6'h00 : ptr_q + 6'h01;
                    end else if (xfer_on) begin
                        if ((next_wr_q && xfer_wr_ok) || !xfer_rd_ok) begin
                            msg_kind_o   <= MSG_XFER_WR;
                            msg_remote_o <= wr_rem_q;
                            msg_local_o  <= wr_loc_q;
                            msg_count_o  <= wr_cnt_q;
                            next_wr_q    <= 1'b0;
                        end else begin
                            msg_kind_o   <= MSG_XFER_RD;
                            msg_remote_o <= rd_rem_q;
                            msg_local_o  <= rd_loc_q;
                            msg_count_o  <= rd_cnt_q;
                            next_wr_q    <= xfer_wr_ok;
                        end
                        msg_req_o   <= 1'b1;
                        busy_q      <= 1'b1;
                        msg_entry_o <= 6'h00;
                        msg_route_o <= xroute_q;
                        state_q     <= ST_WAIT;
                    end else begin
                        state_q <= ST_WAIT;
                    end
                end
                default: state_q <= ST_WAIT;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Entry status bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_q <= '0;
        end else if (ce_i) begin
            for (int i = 0; i < SCAN_ENTRIES; i++) begin
                if (rsp_valid_i && busy_q && msg_kind_o[1] &&
                    last_entry_q == 6'(i)) begin
                    stat_q[i] <= rsp_ok_i && valid[i];
                end else if (!valid[i] || interval_q == 16'h0000) begin
                    stat_q[i] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port role
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_master_o  <= 1'b0;
            slave_refuse_o <= 1'b0;
        end else if (ce_i) begin
            port_master_o  <= ctrl_q[CTRL_OPEN_PROTO] && (scan_on || xfer_on);
            slave_refuse_o <= ctrl_q[CTRL_OPEN_PROTO] && scan_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    scan_issue_valid_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(msg_req_o) && msg_kind_o[1] |-> $past(valid[ptr_q]) && msg_entry_o == $past(ptr_q))
        else $error("Scan message issued for invalid entry");

    xfer_off_scan_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(msg_req_o) && $past(any_valid) |-> msg_kind_o[1])
        else $error("Single transfer issued while scan table valid");

    zero_int_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        interval_q == 16'h0000 && $past(interval_q) == 16'h0000 |-> !$rose(msg_req_o))
        else $error("Message issued with zero interval");

    one_outstanding_a: assert property (@(posedge clk_i) disable iff (rst_i)
        msg_req_o && !msg_ack_i |=> msg_req_o && $stable(msg_kind_o))
        else $error("Request dropped before accept");

    count_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(msg_req_o) |-> msg_count_o <= 8'(MAX_COUNT))
        else $error("Message count above limit");

    local_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(msg_req_o) && msg_kind_o[1] |-> local_ok(msg_local_o))
        else $error("Scan local pointer out of range");

    refuse_master_a: assert property (@(posedge clk_i) disable iff (rst_i)
        slave_refuse_o |-> port_master_o)
        else $error("Slave refused without master role");

    backoff_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && state_q == ST_WAIT && tick && busy_q && !rsp_valid_i &&
        (scan_on || xfer_on) && tick_cnt_q + 16'h0001 >= interval_q
        |=> state_q == ST_BACKOFF)
        else $error("Late reply did not start back-off");

    stat_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !valid[0] && !(rsp_valid_i && busy_q && msg_kind_o[1])
        |=> !stat_q[0])
        else $error("Status bit kept for disabled entry");

endmodule

/* File: test/remote_slave_model.sv */
// Model of the remote slave devices answering scheduled messages
`timescale 1ns/100ps
module remote_slave_model (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Message side
    input  wire logic        msg_req_i,
    input  wire logic [15:0] msg_remote_i,
    output logic             msg_ack_o,
    output logic             rsp_valid_o,
    output logic             rsp_ok_o,
    // Behaviour control
    input  wire logic [3:0]  delay_i,
    input  wire logic        silent_i
);
    logic [3:0] wait_q;
    logic [4:0] left_q;
    logic       fail_q;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Accept after delay, reply later; remote bit 15 asks for an error reply
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            msg_ack_o   <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_ok_o    <= 1'b0;
            wait_q      <= 4'h0;
            left_q      <= 5'h00;
            fail_q      <= 1'b0;
        end else begin
            msg_ack_o   <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_ok_o    <= ~rsp_ok_o;
            if (msg_req_i && !msg_ack_o && left_q == 5'h00) begin
                if (wait_q >= delay_i) begin
                    msg_ack_o <= 1'b1;
                    wait_q    <= 4'h0;
                    fail_q    <= msg_remote_i[15];
                    left_q    <= silent_i ? 5'h00 : {1'b0, delay_i} + 5'h03;
                end else begin
                    wait_q <= wait_q + 4'h1;
                end
            end
            if (left_q == 5'h01) begin
                rsp_valid_o <= 1'b1;
                rsp_ok_o    <= ~fail_q;
            end
            if (left_q != 5'h00) begin
                left_q <= left_q - 5'h01;
            end
        end
    end
endmodule

/* File: test/test_periodic_poll_scheduler.sv */
// Testbench of the periodic poll scheduler
`timescale 1ns/100ps
module test_periodic_poll_scheduler
    import poll_sched_pkg::*;
;
    localparam int T = 10;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, msg_req_o, msg_ack_i, rsp_valid_i, rsp_ok_i;
    logic        port_master_o, slave_refuse_o;
    logic [1:0]  msg_kind_o;
    logic [5:0]  msg_entry_o;
    logic [15:0] msg_remote_o, msg_route_o;
    logic [11:0] msg_local_o;
    logic [7:0]  msg_count_o;
    logic [3:0]  delay = 4'h0;
    logic        silent = 1'b0;
    logic        ce = 1'b1;
    logic [3:0]  sel = 4'hf;
    logic [59:0] lg[$];
    int          lt[$];
    int          err_total = 0;
    int          checks = 0;
    int          cyc_n = 0;
    int          seed = 32'h5870;

    poll_sched #(.TICK_DIV(T)) dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .msg_req_o(msg_req_o), .msg_kind_o(msg_kind_o), .msg_entry_o(msg_entry_o),
        .msg_remote_o(msg_remote_o), .msg_local_o(msg_local_o), .msg_count_o(msg_count_o),
        .msg_route_o(msg_route_o), .msg_ack_i(msg_ack_i), .rsp_valid_i(rsp_valid_i),
        .rsp_ok_i(rsp_ok_i), .port_master_o(port_master_o), .slave_refuse_o(slave_refuse_o));
    remote_slave_model partner (.clk_i(clk_i), .rst_i(rst_i), .msg_req_i(msg_req_o),
        .msg_remote_i(msg_remote_o), .msg_ack_o(msg_ack_i), .rsp_valid_o(rsp_valid_i),
        .rsp_ok_o(rsp_ok_i), .delay_i(delay), .silent_i(silent));

    ////////////////////////////////////////////////////////////////////////////////////////
    // Clock, message log, timeout
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (msg_req_o === 1'b1 && msg_ack_i === 1'b1) begin
            lg.push_back({msg_kind_o, msg_entry_o, msg_remote_o, msg_local_o, msg_count_o,
                          msg_route_o});
            lt.push_back(int'($time / 10));
        end
    end
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            err_total++;
            $display("mismatch at %0t: run timed out", $time);
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Tasks and expectations
    task print_verdict;
        if (err_total == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task gap(input int d, input int n, input int s);
        chk(d < (n - 1) * T || d > (n + 1) * T + s, 1'b0);
    endtask
    task wb(input logic we, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= sel;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
        chk(wb_ack_o, 1'b0);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task ent(input int i, input logic [11:0] l, input logic [15:0] r, input logic d,
             input logic [7:0] c, input logic [15:0] rt);
        wr(ADDR_SCAN_BASE + 12'(8 * i), {4'h0, l, r});
        wr(ADDR_SCAN_BASE + 12'(8 * i + 4), {rt, 7'h0, d, c});
    endtask
    task wait_msgs(input int n);
        int k;
        k = 0;
        while (lg.size() < n && k < 6000) begin
            @(posedge clk_i);
            k++;
        end
        chk(lg.size() >= n, 1'b1);
    endtask
    task quiet(input int n);
        repeat (16) @(posedge clk_i);
        lg.delete();
        lt.delete();
        repeat (n) @(posedge clk_i);
    endtask
    function automatic logic [59:0] em(input logic [1:0] k, input logic [5:0] e,
        input logic [15:0] r, input logic [11:0] l, input logic [7:0] c, input logic [15:0] rt);
        return {k, e, r, l, c, rt};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [15:0] rr, wrr, rt;
        logic [11:0] rl, wl;
        logic [7:0]  rc, wc;
        logic [59:0] ex[3];
        int          k0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({msg_req_o, port_master_o, slave_refuse_o}, 3'b000);
        rd(ADDR_INTERVAL, {16'h0, INTERVAL_RST});
        sel = 4'h3;
        wr(ADDR_INTERVAL, 32'h5);
        sel = 4'hf;
        rd(ADDR_INTERVAL, {16'h0, INTERVAL_RST});
        wr(12'hffc, 32'hffff_ffff);
        rd(12'hffc, 32'h0);
        // Single transfer with random fields
        rc = 8'(($random(seed) & 32'h7f) + 1);
        wc = 8'(($random(seed) & 32'h7f) + 1);
        rl = 12'(($random(seed) & 32'h7ff) + 1);
        wl = 12'(($random(seed) & 32'h7ff) + 1);
        rr = {1'b0, 15'($random(seed))};
        wrr = {1'b0, 15'($random(seed))};
        rt = 16'($random(seed)) | 16'h0001;
        delay <= 4'($random(seed) & 7);
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_XFER_RD, {24'h0, rc});
        wr(ADDR_XFER_RDA, {4'h0, rl, rr});
        wr(ADDR_XFER_WR, {24'h0, wc});
        wr(ADDR_XFER_WRA, {4'h0, wl, wrr});
        wr(ADDR_XFER_ROUTE, {16'h0, rt});
        wr(ADDR_INTERVAL, 32'd4);
        wait_msgs(3);
        chk({lg[0][59:58], lg[0][51:0]}, {MSG_XFER_RD, rr, rl, rc, rt});
        chk({lg[1][59:58], lg[1][51:0]}, {MSG_XFER_WR, wrr, wl, wc, rt});
        chk(lg[2][59:58], MSG_XFER_RD);
        gap(lt[1] - lt[0], 4, 8);
        chk({port_master_o, slave_refuse_o}, 2'b10);
        // Unanswered poll
        silent <= 1'b1;
        quiet(0);
        wait_msgs(3);
        gap(lt[2] - lt[1], 4 + BACKOFF_TICKS, 8);
        silent <= 1'b0;
        // Write count zero
        wr(ADDR_XFER_WR, 32'h0);
        quiet(0);
        wait_msgs(4);
        for (int i = 1; i < 4; i++) chk(lg[i][59:58], MSG_XFER_RD);
        // Zero interval, then zero read count
        wr(ADDR_INTERVAL, 32'h0);
        quiet(20 * T);
        chk(64'(lg.size()), 64'h0);
        wr(ADDR_XFER_RD, 32'h0);
        wr(ADDR_INTERVAL, 32'd4);
        quiet(20 * T);
        chk(64'(lg.size()), 64'h0);
        chk({port_master_o, slave_refuse_o}, 2'b00);
        // Scan table with invalid entries among valid ones
        wr(ADDR_CTRL, 32'h3);
        ent(0, 12'd5, 16'd10, 1'b0, 8'd3, 16'h0101);
        ent(1, 12'd40, 16'd1, 1'b0, 8'd1, 16'h0101);
        ent(2, 12'd65, 16'h8001, 1'b1, 8'd128, 16'h0202);
        ent(3, 12'd32, 16'd1, 1'b0, 8'd0, 16'h0101);
        ent(4, 12'd32, 16'd1, 1'b0, 8'd1, 16'h0000);
        ent(5, 12'd2049, 16'd1, 1'b0, 8'd1, 16'h0101);
        ent(6, 12'd7, 16'd0, 1'b0, 8'd1, 16'h0101);
        ent(47, 12'd2048, 16'h7fff, 1'b1, 8'd1, 16'h0303);
        wr(ADDR_XFER_RD, {24'h0, rc});
        quiet(0);
        wait_msgs(7);
        ex[0] = em(MSG_SCAN_RD, 6'd0, 16'd10, 12'd5, 8'd3, 16'h0101);
        ex[1] = em(MSG_SCAN_WR, 6'd2, 16'h8001, 12'd65, 8'd128, 16'h0202);
        ex[2] = em(MSG_SCAN_WR, 6'd47, 16'h7fff, 12'd2048, 8'd1, 16'h0303);
        k0 = lg[0][57:52] == 6'd0 ? 0 : (lg[0][57:52] == 6'd2 ? 1 : 2);
        for (int i = 0; i < 6; i++) begin
            chk(lg[i], ex[(k0 + i) % 3]);
            gap(lt[i + 1] - lt[i], 4, 60);
        end
        chk({port_master_o, slave_refuse_o}, 2'b11);
        repeat (12) @(posedge clk_i);
        rd(ADDR_SCAN_STAT0, 32'h1);
        rd(ADDR_SCAN_STAT1, 32'h0);
        rd(ADDR_SCAN_STAT2, 32'h8000);
        wr(ADDR_CTRL, 32'h1);
        rd(ADDR_SCAN_STAT0, 32'h0);
        wr(ADDR_CTRL, 32'h3);
        ent(0, 12'd0, 16'd10, 1'b0, 8'd3, 16'h0101);
        repeat (5) @(posedge clk_i);
        rd(ADDR_SCAN_STAT0, 32'h0);
        // Clock enable low freezes the scheduler
        quiet(0);
        wait_msgs(1);
        ce <= 1'b0;
        quiet(20 * T);
        chk(64'(lg.size()), 64'h0);
        print_verdict();
    end
endmodule
